// >>> design/pacs_params.svh
// Constants for the plot axis and channel select block.
// Assumes inclusion by bare name from design files under design/.
`ifndef PACS_PARAMS_SVH
`define PACS_PARAMS_SVH

// Coordinate width and signed working width
`define PACS_CW 16
`define PACS_SW 18

// Hard-clip limits in plotter units
`define PACS_CLIP_XMIN 16'h0000
`define PACS_CLIP_XMAX 16'h2a30
`define PACS_CLIP_YMIN 16'h0000
`define PACS_CLIP_YMAX 16'h1d4c

// Default zero and full-scale positions, near opposite corners
`define PACS_ZERO_X_RST 16'h0190
`define PACS_ZERO_Y_RST 16'h0190
`define PACS_FS_X_RST 16'h28a0
`define PACS_FS_Y_RST 16'h1bbc

// Selection reset values and fixed masks
`define PACS_YEN_RST 3'h1
`define PACS_XCH3_RST 1'b0
`define PACS_YEN_CH1 3'h1
`define PACS_YEN_NOCH3 3'h3
`define PACS_FILL_ALL 3'h7
`define PACS_NONE 3'h0

// Quadrant codes
`define PACS_Q1 2'h0
`define PACS_Q2 2'h1
`define PACS_Q3 2'h2
`define PACS_Q4 2'h3

`endif

// >>> design/pacs_pkg.sv
// Types for the plot axis and channel select block.
// Assumes the params header is compiled alongside.
package pacs_pkg;
   typedef logic [15:0] pacs_coord_t;
   typedef logic signed [17:0] pacs_scoord_t;
   typedef enum logic [1:0] {
      PACS_IDLE = 2'b00,
      PACS_DIRECT = 2'b01,
      PACS_FILL = 2'b10,
      PACS_PLOT = 2'b11
   } pacs_state_t;
endpackage : pacs_pkg

// >>> design/pacs_clamp_if.sv
// Interface carrying one value into a clamp and the result back.
// Assumes one clamp instance per interface instance.
`timescale 1ns/1ps
interface pacs_clamp_if;
   pacs_pkg::pacs_scoord_t val;
   pacs_pkg::pacs_coord_t lo;
   pacs_pkg::pacs_coord_t hi;
   pacs_pkg::pacs_coord_t res;
   logic clip;
   modport clamp (input val, input lo, input hi, output res, output clip);
   modport user (output val, output lo, output hi, input res, input clip);
endinterface : pacs_clamp_if

// >>> design/pacs_clamp.sv
// Combinational clamp of one signed coordinate to a window.
// Assumes lo is not above hi.
`timescale 1ns/1ps
module pacs_clamp (
   pacs_clamp_if.clamp c
);
   wire below;
   wire above;
   // Window compare in signed working width
   assign below = c.val < $signed({2'b00, c.lo});
   assign above = c.val > $signed({2'b00, c.hi});
   assign c.clip = below | above;
   assign c.res = below ? c.lo : (above ? c.hi : c.val[15:0]);
endmodule : pacs_clamp

// >>> design/pacs_top.sv
// Axis and channel selection with zero/full-scale points and clipping.
// Assumes button inputs are same-clock one-cycle pulses from a debouncer,
// and sequencer strobes are same-clock pulses.
// Function
// - X button flips time / channel three
// - Three Y enables toggle per button
// - All Y clear forces channel one on
// - Channel three on X blocks its Y
// - Time or channel three drives X
// - Direct plots only lowest enabled channel
// - Buffered fills all three buffers first
// - Any stored subset plottable after fill
// - Buffered plots ascending from lowest channel
// - Reset loads default zero/full-scale points
// - Zero is origin; quadrants from it
// - Full-scale point marks range full-scale voltages
// - Zero move shifts full-scale, clipped
// - Off-paper points clamped and flagged, still valid
`timescale 1ns/1ps
`include "pacs_params.svh"
module pacs_top (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_xsel_press,
   input wire logic [2:0] i_ych_press,
   input wire logic i_direct_start,
   input wire logic i_buf_start,
   input wire logic i_rec_stop,
   input wire logic i_fill_done,
   input wire logic i_plot_next,
   input wire logic i_zero_set,
   input wire logic [15:0] i_zero_x,
   input wire logic [15:0] i_zero_y,
   input wire logic i_fs_set,
   input wire logic [15:0] i_fs_x,
   input wire logic [15:0] i_fs_y,
   input wire logic i_pt_valid,
   input wire logic signed [17:0] i_pt_x,
   input wire logic signed [17:0] i_pt_y,
   output logic o_x_ch3,
   output logic o_x_time,
   output logic [2:0] o_y_en,
   output logic [1:0] o_state,
   output logic [2:0] o_direct_ch,
   output logic [2:0] o_fill_en,
   output logic [2:0] o_plot_ch,
   output logic [15:0] o_zero_x,
   output logic [15:0] o_zero_y,
   output logic [15:0] o_fs_x,
   output logic [15:0] o_fs_y,
   output logic o_pt_valid,
   output logic [15:0] o_pt_x,
   output logic [15:0] o_pt_y,
   output logic [1:0] o_pt_quad,
   output logic o_pt_clip
);
   pacs_pkg::pacs_state_t state_r, state_nxt;
   logic x_ch3_r;
   logic [2:0] y_en_r;
   logic [2:0] pend_r, pend_nxt;
   logic [2:0] plot_r, plot_nxt;
   logic [2:0] direct_r;
   wire x_nxt;
   wire [2:0] y_tog;
   wire [2:0] y_mask;
   wire [2:0] y_nxt;
   wire [2:0] y_low;
   wire [2:0] pend_left;
   wire [2:0] pend_low;

   assign x_nxt = x_ch3_r ^ i_xsel_press;
   assign y_tog = y_en_r ^ i_ych_press;
   // Channel three masked while it drives X
   assign y_mask = x_nxt ? (y_tog & `PACS_YEN_NOCH3) : y_tog;
   // Never leave all Y enables clear
   assign y_nxt = (y_mask == `PACS_NONE) ? `PACS_YEN_CH1 : y_mask;
   // Lowest set bit of the selections and of the pending plots
   assign y_low = y_en_r & (~y_en_r + 3'h1);
   assign pend_left = pend_r & ~plot_r;
   assign pend_low = pend_left & (~pend_left + 3'h1);

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         x_ch3_r <= `PACS_XCH3_RST;
         o_x_time <= ~`PACS_XCH3_RST;
         y_en_r <= `PACS_YEN_RST;
      end else begin
         x_ch3_r <= x_nxt;
         o_x_time <= ~x_nxt; // Time indicator kept as its own flop
         y_en_r <= y_nxt;
      end
   end

   // Recording sequence
   always_comb begin
      state_nxt = state_r;
      pend_nxt = pend_r;
      plot_nxt = plot_r;
      unique case (state_r)
         pacs_pkg::PACS_IDLE: begin
            if (i_direct_start) begin
               state_nxt = pacs_pkg::PACS_DIRECT;
            end else if (i_buf_start) begin
               state_nxt = pacs_pkg::PACS_FILL;
            end
         end
         pacs_pkg::PACS_DIRECT: begin
            if (i_rec_stop) begin
               state_nxt = pacs_pkg::PACS_IDLE;
            end
         end
         pacs_pkg::PACS_FILL: begin
            // Any current subset taken once buffers are full
            if (i_fill_done) begin
               state_nxt = pacs_pkg::PACS_PLOT;
               pend_nxt = y_en_r;
               plot_nxt = y_low;
            end
         end
         pacs_pkg::PACS_PLOT: begin
            // Step to the next higher enabled channel
            if (i_rec_stop || (i_plot_next && pend_low == `PACS_NONE)) begin
               state_nxt = pacs_pkg::PACS_IDLE;
               pend_nxt = `PACS_NONE;
               plot_nxt = `PACS_NONE;
            end else if (i_plot_next) begin
               pend_nxt = pend_left;
               plot_nxt = pend_low;
            end
         end
      endcase
   end

   // Sequence registers
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_r <= pacs_pkg::PACS_IDLE;
         pend_r <= `PACS_NONE;
         plot_r <= `PACS_NONE;
      end else begin
         state_r <= state_nxt;
         pend_r <= pend_nxt;
         plot_r <= plot_nxt;
      end
   end

   // Lowest channel captured at direct start
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         direct_r <= `PACS_NONE;
      end else if (state_r == pacs_pkg::PACS_IDLE && i_direct_start) begin
         direct_r <= y_low;
      end else if (state_nxt == pacs_pkg::PACS_IDLE) begin
         direct_r <= `PACS_NONE;
      end
   end

   // Clamp channels: full-scale follow and data point, per axis
   pacs_clamp_if fsx_c ();
   pacs_clamp_if fsy_c ();
   pacs_clamp_if ptx_c ();
   pacs_clamp_if pty_c ();
   pacs_clamp u_fsx (.c(fsx_c.clamp));
   pacs_clamp u_fsy (.c(fsy_c.clamp));
   pacs_clamp u_ptx (.c(ptx_c.clamp));
   pacs_clamp u_pty (.c(pty_c.clamp));

   // Full-scale shifted by the zero displacement
   assign fsx_c.val = $signed({2'b00, o_fs_x}) + $signed({2'b00, i_zero_x})
      - $signed({2'b00, o_zero_x});
   assign fsy_c.val = $signed({2'b00, o_fs_y}) + $signed({2'b00, i_zero_y})
      - $signed({2'b00, o_zero_y});
   // Data points limited to the hard-clip window
   assign ptx_c.val = i_pt_x;
   assign pty_c.val = i_pt_y;
   assign fsx_c.lo = `PACS_CLIP_XMIN;
   assign fsx_c.hi = `PACS_CLIP_XMAX;
   assign ptx_c.lo = `PACS_CLIP_XMIN;
   assign ptx_c.hi = `PACS_CLIP_XMAX;
   assign fsy_c.lo = `PACS_CLIP_YMIN;
   assign fsy_c.hi = `PACS_CLIP_YMAX;
   assign pty_c.lo = `PACS_CLIP_YMIN;
   assign pty_c.hi = `PACS_CLIP_YMAX;

   // Reference points; full-scale marks range full-scale
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_zero_x <= `PACS_ZERO_X_RST;
         o_zero_y <= `PACS_ZERO_Y_RST;
         o_fs_x <= `PACS_FS_X_RST;
         o_fs_y <= `PACS_FS_Y_RST;
      end else if (i_zero_set) begin
         o_zero_x <= i_zero_x;
         o_zero_y <= i_zero_y;
         o_fs_x <= fsx_c.res;
         o_fs_y <= fsy_c.res;
      end else if (i_fs_set) begin
         o_fs_x <= i_fs_x;
         o_fs_y <= i_fs_y;
      end
   end

   wire x_neg;
   wire y_neg;
   wire [1:0] quad;
   // Quadrant relative to the zero origin
   assign x_neg = i_pt_x < $signed({2'b00, o_zero_x});
   assign y_neg = i_pt_y < $signed({2'b00, o_zero_y});
   assign quad = x_neg ? (y_neg ? `PACS_Q3 : `PACS_Q2) : (y_neg ? `PACS_Q4 : `PACS_Q1);

   // Registered point path; clipped points flagged, valid kept
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_pt_valid <= 1'b0;
         o_pt_x <= `PACS_CLIP_XMIN;
         o_pt_y <= `PACS_CLIP_YMIN;
         o_pt_quad <= `PACS_Q1;
         o_pt_clip <= 1'b0;
      end else begin
         o_pt_valid <= i_pt_valid;
         o_pt_x <= ptx_c.res;
         o_pt_y <= pty_c.res;
         o_pt_quad <= quad;
         o_pt_clip <= i_pt_valid & (ptx_c.clip | pty_c.clip);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_fill_en <= `PACS_NONE;
      end else begin
         o_fill_en <= (state_nxt == pacs_pkg::PACS_FILL) ? `PACS_FILL_ALL : `PACS_NONE;
      end
   end
   assign o_x_ch3 = x_ch3_r;
   assign o_y_en = y_en_r;
   assign o_state = state_r;
   assign o_direct_ch = direct_r;
   assign o_plot_ch = plot_r;

   // Checks
   xsel_flip_a: assert property (@(posedge i_clk) disable iff (i_srst)
      i_xsel_press |=> (o_x_ch3 != $past(o_x_ch3)) && (o_x_time == !o_x_ch3))
      else $error("x source did not flip");
   ych_toggle_a: assert property (@(posedge i_clk) disable iff (i_srst)
      (i_ych_press == 3'h2 && o_y_en[0]) |=> o_y_en[1] != $past(o_y_en[1]))
      else $error("y enable did not toggle");
   y_nonzero_a: assert property (@(posedge i_clk) disable iff (i_srst)
      (i_ych_press == o_y_en && !i_xsel_press) |=> o_y_en == `PACS_YEN_CH1)
      else $error("empty y selection not forced");
   ch3_excl_a: assert property (@(posedge i_clk) disable iff (i_srst)
      o_x_ch3 |-> !o_y_en[2])
      else $error("channel three on both axes");
   direct_one_a: assert property (@(posedge i_clk) disable iff (i_srst)
      (o_state == pacs_pkg::PACS_IDLE && i_direct_start) |=> $onehot(o_direct_ch)
      && o_direct_ch == ($past(o_y_en) & (~$past(o_y_en) + 3'h1)))
      else $error("direct channel not lowest");
   fill_all_a: assert property (@(posedge i_clk) disable iff (i_srst)
      o_state == pacs_pkg::PACS_FILL |-> o_fill_en == `PACS_FILL_ALL
      && o_plot_ch == `PACS_NONE)
      else $error("fill not on all channels");
   plot_order_a: assert property (@(posedge i_clk) disable iff (i_srst)
      (o_state == pacs_pkg::PACS_PLOT && i_plot_next && !i_rec_stop
      && o_state == $past(o_state))
      |=> o_plot_ch == `PACS_NONE || o_plot_ch > $past(o_plot_ch))
      else $error("plot order not ascending");
   ref_reset_a: assert property (@(posedge i_clk)
      $past(i_srst) |-> o_zero_x == `PACS_ZERO_X_RST && o_zero_y == `PACS_ZERO_Y_RST
      && o_fs_x == `PACS_FS_X_RST && o_fs_y == `PACS_FS_Y_RST)
      else $error("reference points not at defaults");
   fs_follow_a: assert property (@(posedge i_clk) disable iff (i_srst)
      i_zero_set |=> o_fs_x <= `PACS_CLIP_XMAX && o_fs_y <= `PACS_CLIP_YMAX)
      else $error("full scale outside clip window");
   pt_clamp_a: assert property (@(posedge i_clk) disable iff (i_srst)
      (i_pt_valid && i_pt_x > $signed({2'b00, `PACS_CLIP_XMAX}))
      |=> o_pt_clip && o_pt_x == `PACS_CLIP_XMAX)
      else $error("point not clamped");
endmodule : pacs_top

// >>> dv/pacs_panel.sv
// Front-panel push-button model for the axis and channel select block.
// Assumes the bench calls its tasks; pulses change at falling edges.
`timescale 1ns/1ps
module pacs_panel (
   input wire logic i_clk,
   output logic o_xsel_press,
   output logic [2:0] o_ych_press
);
   // Buttons idle low
   initial begin
      o_xsel_press = 1'b0;
      o_ych_press = 3'h0;
   end

   task automatic press_x();
      @(negedge i_clk);
      o_xsel_press = 1'b1;
      @(negedge i_clk);
      o_xsel_press = 1'b0;
   endtask : press_x

   // One-cycle press pulses, several channels at once allowed
   task automatic press_y(input logic [2:0] v);
      @(negedge i_clk);
      o_ych_press = v;
      @(negedge i_clk);
      o_ych_press = 3'h0;
   endtask : press_y
endmodule : pacs_panel

// >>> dv/tb_pacs_top.sv
// Self-checking bench for the axis and channel select block.
// Assumes the design header and package are compiled first.
`timescale 1ns/1ps
`include "pacs_params.svh"
module tb_pacs_top;
   logic i_clk, i_srst, xp, ds, bs, st, fd, pn, zs, fs, pv;
   logic [2:0] yp;
   logic [15:0] zx, zy, fx, fy;
   logic signed [17:0] px, py;
   logic x3, xt, ptv, clip;
   logic [2:0] yen, dch, fen, pch;
   logic [1:0] state, quad;
   logic [15:0] ozx, ozy, ofx, ofy, ptx, pty;
   int errors, tests_run;

   pacs_panel u_pan (.i_clk(i_clk), .o_xsel_press(xp), .o_ych_press(yp));

   pacs_top u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_xsel_press(xp), .i_ych_press(yp),
      .i_direct_start(ds), .i_buf_start(bs), .i_rec_stop(st), .i_fill_done(fd),
      .i_plot_next(pn), .i_zero_set(zs), .i_zero_x(zx), .i_zero_y(zy), .i_fs_set(fs),
      .i_fs_x(fx), .i_fs_y(fy), .i_pt_valid(pv), .i_pt_x(px), .i_pt_y(py),
      .o_x_ch3(x3), .o_x_time(xt), .o_y_en(yen), .o_state(state), .o_direct_ch(dch),
      .o_fill_en(fen), .o_plot_ch(pch), .o_zero_x(ozx), .o_zero_y(ozy), .o_fs_x(ofx),
      .o_fs_y(ofy), .o_pt_valid(ptv), .o_pt_x(ptx), .o_pt_y(pty), .o_pt_quad(quad),
      .o_pt_clip(clip));

   // Clock, 8 ns period
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   // Compare and count
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One-cycle strobe helper: waits one falling edge after raising
   task automatic tick();
      @(negedge i_clk);
   endtask : tick

   // Verdict and end of run
   task automatic end_sim();
      if (errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   // Watchdog
   initial begin
      #20000;
      errors++;
      end_sim();
   end

   // Main sequence
   initial begin
      {ds, bs, st, fd, pn, zs, fs, pv} = 8'h00;
      zx = 16'h0000;
      zy = 16'h0000;
      fx = 16'h0000;
      fy = 16'h0000;
      px = 18'sh00000;
      py = 18'sh00000;
      i_srst = 1'b1;
      repeat (4) tick();
      i_srst = 1'b0;
      tick();
      chk("x_time", 16'h1, xt);
      chk("y_en", `PACS_YEN_RST, yen);
      chk("state", 16'h0, state);
      chk("zero_x", `PACS_ZERO_X_RST, ozx);
      chk("zero_y", `PACS_ZERO_Y_RST, ozy);
      chk("fs_x", `PACS_FS_X_RST, ofx);
      chk("fs_y", `PACS_FS_Y_RST, ofy);
      u_pan.press_y(3'b010);
      chk("y_en", 16'h3, yen);
      u_pan.press_y(3'b011);
      chk("y_en", 16'h1, yen);
      u_pan.press_y(3'b100);
      chk("y_en", 16'h5, yen);
      u_pan.press_x();
      chk("x_ch3", 16'h1, x3);
      chk("x_time", 16'h0, xt);
      chk("y_en", 16'h1, yen);
      u_pan.press_y(3'b110);
      chk("y_en", 16'h3, yen);
      u_pan.press_x();
      chk("x_time", 16'h1, xt);
      u_pan.press_y(3'b101);
      chk("y_en", 16'h6, yen);
      // Selections finished before the direct start
      ds = 1'b1;
      tick();
      ds = 1'b0;
      chk("state", 16'h1, state);
      chk("direct_ch", 16'h2, dch);
      u_pan.press_y(3'b010);
      chk("direct_ch", 16'h2, dch);
      bs = 1'b1;
      tick();
      bs = 1'b0;
      chk("state", 16'h1, state);
      st = 1'b1;
      tick();
      st = 1'b0;
      chk("direct_ch", 16'h0, dch);
      u_pan.press_y(3'b001);
      bs = 1'b1;
      tick();
      bs = 1'b0;
      chk("state", 16'h2, state);
      chk("fill_en", `PACS_FILL_ALL, fen);
      fd = 1'b1;
      tick();
      fd = 1'b0;
      chk("state", 16'h3, state);
      chk("plot_ch", 16'h1, pch);
      pn = 1'b1;
      tick();
      chk("plot_ch", 16'h4, pch);
      tick();
      pn = 1'b0;
      chk("state", 16'h0, state);
      chk("plot_ch", 16'h0, pch);
      // Fill done outside a fill is ignored
      fd = 1'b1;
      tick();
      fd = 1'b0;
      chk("state", 16'h0, state);
      bs = 1'b1;
      tick();
      bs = 1'b0;
      u_pan.press_y(3'b010);
      chk("y_en", 16'h7, yen);
      chk("fill_en", `PACS_FILL_ALL, fen);
      fd = 1'b1;
      tick();
      fd = 1'b0;
      chk("state", 16'h3, state);
      chk("fill_en", 16'h0, fen);
      chk("plot_ch", 16'h1, pch);
      pn = 1'b1;
      tick();
      pn = 1'b0;
      chk("plot_ch", 16'h2, pch);
      // Stop aborts the buffered plot
      st = 1'b1;
      tick();
      st = 1'b0;
      chk("state", 16'h0, state);
      chk("plot_ch", 16'h0, pch);
      // Direct wins over buffered when both start together
      ds = 1'b1;
      bs = 1'b1;
      tick();
      ds = 1'b0;
      bs = 1'b0;
      chk("state", 16'h1, state);
      chk("direct_ch", 16'h1, dch);
      st = 1'b1;
      tick();
      st = 1'b0;
      chk("state", 16'h0, state);
      zx = 16'h1000;
      zy = 16'h1000;
      zs = 1'b1;
      tick();
      zs = 1'b0;
      tick();
      chk("zero_x", 16'h1000, ozx);
      chk("zero_y", 16'h1000, ozy);
      chk("fs_x", `PACS_CLIP_XMAX, ofx);
      chk("fs_y", `PACS_CLIP_YMAX, ofy);
      fx = 16'h2000;
      fy = 16'h1800;
      fs = 1'b1;
      tick();
      fs = 1'b0;
      chk("fs_x", 16'h2000, ofx);
      chk("fs_y", 16'h1800, ofy);
      px = -18'sd5;
      py = 18'sh03000;
      pv = 1'b1;
      tick();
      chk("pt_valid", 16'h1, ptv);
      chk("pt_x", `PACS_CLIP_XMIN, ptx);
      chk("pt_y", `PACS_CLIP_YMAX, pty);
      chk("pt_clip", 16'h1, clip);
      chk("pt_quad", `PACS_Q2, quad);
      px = 18'sh02000;
      py = 18'sh00800;
      tick();
      chk("pt_x", 16'h2000, ptx);
      chk("pt_y", 16'h0800, pty);
      chk("pt_clip", 16'h0, clip);
      chk("pt_quad", `PACS_Q4, quad);
      px = 18'sh03000;
      py = 18'sh03000;
      tick();
      chk("pt_x", `PACS_CLIP_XMAX, ptx);
      chk("pt_clip", 16'h1, clip);
      chk("pt_quad", `PACS_Q1, quad);
      px = 18'sh00500;
      py = 18'sh00500;
      tick();
      pv = 1'b0;
      px = 18'sh03000;
      chk("pt_y", 16'h0500, pty);
      chk("pt_clip", 16'h0, clip);
      chk("pt_quad", `PACS_Q3, quad);
      tick();
      chk("pt_valid", 16'h0, ptv);
      chk("pt_clip", 16'h0, clip);
      // Zero and full-scale entered together: zero wins
      zx = 16'h0800;
      zy = 16'h0800;
      fx = 16'h1111;
      fy = 16'h1111;
      zs = 1'b1;
      fs = 1'b1;
      tick();
      zs = 1'b0;
      fs = 1'b0;
      chk("zero_y", 16'h0800, ozy);
      chk("fs_x", 16'h1800, ofx);
      chk("fs_y", 16'h1000, ofy);
      u_pan.press_x();
      chk("x_ch3", 16'h1, x3);
      // Reset in mid-run restores the selection and reference-point defaults
      i_srst = 1'b1;
      tick();
      i_srst = 1'b0;
      chk("x_ch3", 16'h0, x3);
      chk("x_time", 16'h1, xt);
      chk("y_en", `PACS_YEN_RST, yen);
      chk("zero_x", `PACS_ZERO_X_RST, ozx);
      chk("zero_y", `PACS_ZERO_Y_RST, ozy);
      chk("fs_x", `PACS_FS_X_RST, ofx);
      chk("fs_y", `PACS_FS_Y_RST, ofy);
      u_pan.press_y(3'b010);
      chk("y_en", 16'h3, yen);
      end_sim();
   end
endmodule : tb_pacs_top
